// ===== src/rsrc_top.sv
// Rail sequencer core: reset flow, per-output sequencing and a slave two-wire host port
`include "rsrc_cfg.svh"

module rsrc_top
	import rsrc_pkg::*;
#(
	parameter int NCH        = 12,                  // Rails 0..7, general outputs 1..4 at 8..11
	parameter int NRAIL      = 8,
	parameter int DLY_W      = 12,                  // Delay in ms
	parameter int VOLT_W     = 10,
	parameter int BOR_CYCLES = `RSRC_BOR_CYCLES,
	parameter int TICK_CYCLES = `RSRC_TICK_CYCLES
) (
	input  wire logic                    ref_clk_i,          // 100 MHz clock
	input  wire logic                    nrst_i,             // Power-on reset, active low
	input  wire logic                    rst_pin_n_i,        // External reset pin, active low
	input  wire logic                    seq_event_i,        // Sequence request from alarm logic
	input  wire logic                    scl_i,              // Bus clock pin level
	input  wire logic                    sda_i,              // Bus data pin level
	output logic                         sda_o,              // Bus data drive value, always low
	output logic                         sda_oe_o,           // Bus data pulled low when high
	input  wire logic [3:0]              bus_address_strap_i, // Address strap pin levels
	input  wire logic                    eighth_is_gpo_i,    // Eighth pin acts as first general output
	input  wire logic [NCH*2-1:0]        ch_mode_i,          // Sequencing mode per output
	input  wire logic [NCH*3-1:0]        ch_parent_i,        // Parent rail per output
	input  wire logic [NCH*DLY_W-1:0]    ch_delay_i,         // Delay per output in ms
	input  wire logic [NCH*VOLT_W-1:0]   ch_thresh_i,        // Parent voltage threshold per output
	input  wire logic [NCH-1:0]          ch_pol_i,           // 1 active high, 0 active low
	input  wire logic [NRAIL-1:0]        rail_in_reg_i,      // Rail within its UV and OV limits
	input  wire logic [NRAIL*VOLT_W-1:0] rail_volt_i,        // Sampled rail voltages
	input  wire logic                    cfg_sum_ok_i,       // Configuration checksum good
	input  wire logic                    cfg_new_i,          // Configuration not yet backed up
	input  wire logic                    cfg_copy_done_i,    // Restore or backup copy finished
	input  wire logic                    ref_sel_ext_i,      // Select supply as converter reference
	output logic [NRAIL-1:0]             rail_enable_out_o,  // Enable pin levels
	output logic [NRAIL-1:0]             rail_enable_oe_o,   // Enable pin drive enables
	output logic [2:0]                   general_output_o,   // General outputs 2..4
	output logic [2:0]                   general_output_oe_o, // General output drive enables
	output logic                         cfg_restore_o,      // Copy last good configuration back
	output logic                         cfg_backup_o,       // Store backup of new configuration
	output logic                         seq_run_o,          // Sequencing active
	output logic [3:0]                   reset_cause_o,      // Cause of the last reset
	output logic [6:0]                   bus_addr_o,         // Assigned slave address
	output logic                         adc_ref_ext_o,      // Converter uses supply reference
	output logic [7:0]                   host_wr_data_o,     // Last byte written by host
	output logic                         host_wr_stb_o       // One-cycle pulse per written byte
);

	localparam logic [17:0] BOR_LAST  = 18'(BOR_CYCLES - 1);
	localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
	localparam logic [7:0]  RST_LAST  = 8'(`RSRC_RST_MIN_CYCLES - 1);

	function automatic logic [VOLT_W-1:0] volt_of(input logic [NRAIL*VOLT_W-1:0] v, input logic [2:0] i);
		return v[i*VOLT_W +: VOLT_W];
	endfunction

	logic [`RSRC_SYNC_W-1:0] sync1_q, sync2_q, sync3_q, filt_q, filt_d;
	logic [7:0]              rstp_cnt_q;
	logic [17:0]             bor_cnt_q;
	logic [16:0]             tick_cnt_q;
	logic                    tick_q;
	rsrc_rst_t               rst_q, rst_d;
	logic [3:0]              cause_q, cause_d;
	logic [6:0]              addr_q;
	logic                    restart_q;
	logic [NCH-1:0]          on_w;
	logic [NCH-1:0]          lvl_w;

	// Pins pass three stages; a bit moves only when stages two and three agree
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_q <= `RSRC_SYNC_RST;
			sync2_q <= `RSRC_SYNC_RST;
			sync3_q <= `RSRC_SYNC_RST;
			filt_q  <= `RSRC_SYNC_RST;
		end else begin
			sync1_q <= {bus_address_strap_i, rst_pin_n_i, sda_i, scl_i};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q  <= filt_d;
		end
	end
	assign filt_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));

	// Reset pin qualification: shorter pulses are treated as noise
	wire rstp_low = ~filt_q[`RSRC_S_RSTP];
	wire pin_rst  = rstp_low & (rstp_cnt_q == RST_LAST);
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rstp_cnt_q <= 8'h00;
		end else if (!rstp_low) begin
			rstp_cnt_q <= 8'h00;
		end else if (rstp_cnt_q != RST_LAST) begin
			rstp_cnt_q <= rstp_cnt_q + 8'h01;
		end
	end

	wire run      = (rst_q == R_RUN);
	wire bor_done = (bor_cnt_q == BOR_LAST);

	// Reset flow; a held reset pin parks the flow in the tri-state step
	always_comb begin
		rst_d   = rst_q;
		cause_d = cause_q;
		unique case (rst_q)
			R_BOR:     if (bor_done) rst_d = R_HIZ;
			R_HIZ:     if (!pin_rst) rst_d = R_INACT;
			R_INACT:   rst_d = R_CHK;
			R_CHK: begin
				if (!cfg_sum_ok_i) begin
					rst_d = R_RESTORE;
				end else if (cfg_new_i) begin
					rst_d = R_BACKUP;
				end else begin
					rst_d = R_RUN;
				end
			end
			R_RESTORE: if (cfg_copy_done_i) rst_d = R_RUN;
			R_BACKUP:  if (cfg_copy_done_i) rst_d = R_RUN;
			R_RUN: begin
				if (seq_event_i) begin
					rst_d   = R_OFF;
					cause_d = 4'h1 << `RSRC_CAUSE_SEQ;
				end else if (restart_q) begin
					rst_d   = R_HIZ;
					cause_d = 4'h1 << `RSRC_CAUSE_CMD;
				end
			end
			R_OFF:     rst_d = R_HIZ;
		endcase
		// Pin reset beats every other cause once the brownout wait is over
		if (pin_rst && rst_q != R_BOR) begin
			rst_d   = R_HIZ;
			cause_d = 4'h1 << `RSRC_CAUSE_PIN;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_q     <= R_BOR;
			cause_q   <= `RSRC_CAUSE_RST;
			bor_cnt_q <= 18'h00000;
		end else begin
			rst_q     <= rst_d;
			cause_q   <= cause_d;
			bor_cnt_q <= (rst_q == R_BOR && !bor_done) ? bor_cnt_q + 18'h00001 : bor_cnt_q;
		end
	end

	// Straps are read while all pins float, as the eighth pin doubles as a strap
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_q <= 7'h00;
		end else if (rst_q == R_HIZ) begin
			addr_q <= {`RSRC_I2C_BASE, filt_q[`RSRC_S_STRAP +: 4]};
		end
	end

	// Millisecond tick; held at zero outside sequencing so delays start aligned
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_cnt_q <= 17'h00000;
			tick_q     <= 1'h0;
		end else begin
			tick_cnt_q <= (!run || tick_cnt_q == TICK_LAST) ? 17'h00000 : tick_cnt_q + 17'h00001;
			tick_q     <= run && tick_cnt_q == TICK_LAST;
		end
	end

	// One sequencer per output; rails and general outputs share the same logic
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		logic [DLY_W-1:0] tmr_q;
		logic             on_q;
		rsrc_mode_t       mode;
		logic [2:0]       par;
		logic             preg;
		logic             reached;
		logic             on_d;
		logic             cnt_en;
		logic             cnt_clr;
		assign mode    = rsrc_mode_t'(ch_mode_i[g*2 +: 2]);
		assign par     = ch_parent_i[g*3 +: 3];
		assign preg    = rail_in_reg_i[par];
		assign reached = tmr_q >= ch_delay_i[g*DLY_W +: DLY_W];
		assign on_d    = (mode == MODE_RESET) ? reached :
		                 (mode == MODE_PREG)  ? preg & reached :
		                 (mode == MODE_PVOLT) ? volt_of(rail_volt_i, par) >= ch_thresh_i[g*VOLT_W +: VOLT_W] :
		                 1'h0;
		assign cnt_en  = tick_q && !reached && (mode == MODE_RESET || (mode == MODE_PREG && preg));
		// Parent leaving regulation before assertion restarts its delay
		assign cnt_clr = !run || (mode == MODE_PREG && !preg && !on_q);
		always_ff @(posedge ref_clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				tmr_q <= '0;
				on_q  <= 1'h0;
			end else begin
				tmr_q <= cnt_clr ? '0 : (cnt_en ? tmr_q + DLY_W'(1'h1) : tmr_q);
				on_q  <= run && (on_q || on_d);
			end
		end
		assign on_w[g]  = on_q;
		// Inactive level is the inverse of the active polarity
		assign lvl_w[g] = ~((on_q & run) ^ ch_pol_i[g]);
	end

	wire drive = (rst_q != R_BOR) && (rst_q != R_HIZ);

	// Pin drivers; the eighth pin follows whichever function owns it
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rail_enable_out_o   <= '0;
			rail_enable_oe_o    <= '0;
			general_output_o    <= 3'h0;
			general_output_oe_o <= 3'h0;
		end else begin
			rail_enable_out_o   <= {eighth_is_gpo_i ? lvl_w[8] : lvl_w[7], lvl_w[6:0]};
			rail_enable_oe_o    <= {NRAIL{drive}};
			general_output_o    <= lvl_w[11:9];
			general_output_oe_o <= {3{drive}};
		end
	end

	// Status and configuration-copy outputs
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_restore_o <= 1'h0;
			cfg_backup_o  <= 1'h0;
			seq_run_o     <= 1'h0;
			reset_cause_o <= `RSRC_CAUSE_RST;
			bus_addr_o    <= 7'h00;
			adc_ref_ext_o <= 1'h0;
		end else begin
			cfg_restore_o <= rst_d == R_RESTORE;
			cfg_backup_o  <= rst_d == R_BACKUP;
			seq_run_o     <= run;
			reset_cause_o <= cause_q;
			bus_addr_o    <= addr_q;
			adc_ref_ext_o <= ref_sel_ext_i;
		end
	end

	// Two-wire slave; the 100 kHz bus is oversampled, so edges are plain level changes
	rsrc_i2c_t  i_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic       rw_q;
	logic       scl_p_q, sda_p_q;
	wire        scl_f  = filt_q[`RSRC_S_SCL];
	wire        sda_f  = filt_q[`RSRC_S_SDA];
	wire        i_start = scl_f & scl_p_q & sda_p_q & ~sda_f;
	wire        i_stop  = scl_f & scl_p_q & ~sda_p_q & sda_f;
	wire        i_rise  = scl_f & ~scl_p_q;
	wire        i_fall  = ~scl_f & scl_p_q;
	wire [7:0]  stat_w  = {run, 3'h0, cause_q};
	wire        full    = (bit_q == `RSRC_BIT_FULL);

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			i_q <= I_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rw_q <= 1'h0;
			scl_p_q <= 1'h1;
			sda_p_q <= 1'h1;
			sda_o <= 1'h0;
			sda_oe_o <= 1'h0;
			host_wr_data_o <= 8'h00;
			host_wr_stb_o <= 1'h0;
			restart_q <= 1'h0;
		end else begin
			scl_p_q <= scl_f;
			sda_p_q <= sda_f;
			host_wr_stb_o <= 1'h0;
			restart_q <= 1'h0;
			if (!run || i_stop) begin
				i_q <= I_IDLE;
				sda_oe_o <= 1'h0;
			end else if (i_start) begin
				i_q <= I_ADDR;
				bit_q <= 4'h0;
				sda_oe_o <= 1'h0;
			end else if (i_rise) begin
				unique case (i_q)
					I_ADDR, I_RX: begin
						sh_q <= {sh_q[6:0], sda_f};
						bit_q <= bit_q + 4'h1;
					end
					I_TACK: i_q <= sda_f ? I_IDLE : I_ACK;  // Master NACK ends a read
					default: ;
				endcase
			end else if (i_fall) begin
				unique case (i_q)
					I_ADDR: if (full) begin
						rw_q <= sh_q[0];
						i_q <= (sh_q[7:1] == addr_q) ? I_ACK : I_IDLE;
						sda_oe_o <= sh_q[7:1] == addr_q;
					end
					I_ACK: begin
						bit_q <= rw_q ? 4'h1 : 4'h0;
						i_q <= rw_q ? I_TX : I_RX;
						sda_oe_o <= rw_q & ~stat_w[7];
						sh_q <= {stat_w[6:0], 1'h0};
					end
					I_RX: if (full) begin
						i_q <= I_RACK;
						sda_oe_o <= 1'h1;
						host_wr_data_o <= sh_q;
						host_wr_stb_o <= 1'h1;
						restart_q <= sh_q == `RSRC_CMD_RESTART;
					end
					I_RACK: begin
						i_q <= I_RX;
						bit_q <= 4'h0;
						sda_oe_o <= 1'h0;
					end
					I_TX: begin
						if (full) begin
							i_q <= I_TACK;
							sda_oe_o <= 1'h0;
						end else begin
							sda_oe_o <= ~sh_q[7];
							sh_q <= {sh_q[6:0], 1'h0};
							bit_q <= bit_q + 4'h1;
						end
					end
					default: ;
				endcase
			end
		end
	end

endmodule // rsrc_top

// ===== src/rsrc_cfg.svh
// Timing constants, bit positions and fixed codes of the rail sequencer core
`ifndef RSRC_CFG_SVH
`define RSRC_CFG_SVH

`define RSRC_CLK_MHZ        100
`define RSRC_BOR_MAX_US     2000
`define RSRC_RST_MIN_US     2
`define RSRC_TICK_US        1000
`define RSRC_BOR_CYCLES     (`RSRC_BOR_MAX_US * `RSRC_CLK_MHZ)
`define RSRC_RST_MIN_CYCLES (`RSRC_RST_MIN_US * `RSRC_CLK_MHZ)
`define RSRC_TICK_CYCLES    (`RSRC_TICK_US * `RSRC_CLK_MHZ)

`define RSRC_SYNC_W         7
`define RSRC_SYNC_RST       7'h7F
`define RSRC_S_SCL          0
`define RSRC_S_SDA          1
`define RSRC_S_RSTP         2
`define RSRC_S_STRAP        3

`define RSRC_CAUSE_POR      0
`define RSRC_CAUSE_PIN      1
`define RSRC_CAUSE_SEQ      2
`define RSRC_CAUSE_CMD      3
`define RSRC_CAUSE_RST      4'h1

`define RSRC_I2C_BASE       3'h3
`define RSRC_CMD_RESTART    8'hA5
`define RSRC_BIT_FULL       4'h8

`endif

// ===== src/rsrc_pkg.sv
// Types shared by the rail sequencer core
package rsrc_pkg;

	typedef enum logic [1:0] {
		MODE_NONE,
		MODE_RESET,
		MODE_PREG,
		MODE_PVOLT
	} rsrc_mode_t;

	typedef enum logic [2:0] {
		R_BOR,
		R_HIZ,
		R_INACT,
		R_CHK,
		R_RESTORE,
		R_BACKUP,
		R_RUN,
		R_OFF
	} rsrc_rst_t;

	typedef enum logic [2:0] {
		I_IDLE,
		I_ADDR,
		I_ACK,
		I_RX,
		I_RACK,
		I_TX,
		I_TACK
	} rsrc_i2c_t;

endpackage : rsrc_pkg

// ===== verification/rsrc_top_checker.sv
// Concurrent checks on the rail sequencer core ports
module rsrc_top_checker
	import rsrc_pkg::*;
#(
	parameter int NCH = 12
) (
	input wire logic           ref_clk_i,         // Clock
	input wire logic           nrst_i,            // Reset, active low
	input wire logic           ref_sel_ext_i,     // Reference select
	input wire logic [NCH-1:0] ch_pol_i,          // Polarities
	input wire logic [7:0]     rail_enable_out_o, // Enable levels
	input wire logic [7:0]     rail_enable_oe_o,  // Enable drives
	input wire logic [2:0]     general_output_oe_o, // Output drives
	input wire logic           sda_oe_o,          // Data pull
	input wire logic           cfg_restore_o,     // Restore copy
	input wire logic           cfg_backup_o,      // Backup copy
	input wire logic           seq_run_o,         // Running
	input wire logic [3:0]     reset_cause_o,     // Cause
	input wire logic [6:0]     bus_addr_o,        // Address
	input wire logic           adc_ref_ext_o,     // Reference used
	input wire logic           host_wr_stb_o      // Write strobe
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	// Driven rails at their active level; pin 7 left out as its owner can switch
	logic [6:0] act_w;
	assign act_w = (rail_enable_out_o[6:0] ~^ ch_pol_i[6:0]) & rail_enable_oe_o[6:0];

	property p_hiz_drop;
		$fell(seq_run_o) |-> ##[0:3] (rail_enable_oe_o == 8'h00 && general_output_oe_o == 3'h0);
	endproperty
	a_hiz_drop: assert property (p_hiz_drop) else $error("Enables not released on reset");
	property p_cause;
		$onehot(reset_cause_o);
	endproperty
	a_cause: assert property (p_cause) else $error("Reset cause not one-hot");
	property p_addr;
		seq_run_o |-> bus_addr_o[6:4] == 3'h3;
	endproperty
	a_addr: assert property (p_addr) else $error("Address base wrong");
	property p_ref;
		$changed(ref_sel_ext_i) |=> adc_ref_ext_o == $past(ref_sel_ext_i);
	endproperty
	a_ref: assert property (p_ref) else $error("Reference select not followed");
	property p_restore;
		cfg_restore_o |-> !seq_run_o && !cfg_backup_o;
	endproperty
	a_restore: assert property (p_restore) else $error("Restore overlaps run");
	property p_backup;
		$fell(cfg_backup_o) |-> ##[0:3] seq_run_o;
	endproperty
	a_backup: assert property (p_backup) else $error("No run after backup");
	// Once asserted an output stays asserted while running
	property p_latch;
		seq_run_o && $past(seq_run_o) |-> ($past(act_w) & ~act_w) == 7'h00;
	endproperty
	a_latch: assert property (p_latch) else $error("Output dropped while running");
	property p_quiet;
		!seq_run_o |-> !sda_oe_o && !host_wr_stb_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("Bus answered during reset");
	property p_drive;
		seq_run_o |-> rail_enable_oe_o == 8'hFF;
	endproperty
	a_drive: assert property (p_drive) else $error("Enables not driven while running");
endmodule // rsrc_top_checker

bind rsrc_top rsrc_top_checker #(.NCH(NCH)) rsrc_top_checker_inst (.ref_clk_i, .nrst_i, .ref_sel_ext_i,
	.ch_pol_i, .rail_enable_out_o, .rail_enable_oe_o, .general_output_oe_o, .sda_oe_o, .cfg_restore_o,
	.cfg_backup_o, .seq_run_o, .reset_cause_o, .bus_addr_o, .adc_ref_ext_o, .host_wr_stb_o);

// ===== verification/rsrc_supply_model.sv
// Behavioural model of eight supplies fed by the enable pins
module rsrc_supply_model #(
	parameter int         STEP = 8,
	parameter logic [9:0] UV   = 10'h200
) (
	input  wire logic       ref_clk_i, // Clock
	input  wire logic [7:0] en_i,      // Enable pin levels
	input  wire logic [7:0] oe_i,      // Enable pin drives
	input  wire logic [7:0] pol_i,     // Active level per pin
	output logic [7:0]      in_reg_o,  // Supply in regulation
	output logic [79:0]     volt_o     // Supply voltages
);
	timeunit 1ns;
	timeprecision 100ps;
	// Undriven pins are pulled to the disabled level, so the supply drops to zero in one cycle
	for (genvar i = 0; i < 8; i++) begin : g_sup
		logic [9:0] v_q = 10'h000;
		always_ff @(posedge ref_clk_i) begin
			if (oe_i[i] && en_i[i] == pol_i[i])
				v_q <= (v_q > 10'h3E0) ? 10'h3F0 : v_q + 10'(STEP);
			else
				v_q <= 10'h000;
		end
		assign volt_o[i*10 +: 10] = v_q;
		assign in_reg_o[i] = v_q >= UV;
	end
endmodule // rsrc_supply_model

// ===== verification/rsrc_top_bench.sv
// Self-checking bench of the rail sequencer core
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
module rsrc_top_bench;
	import rsrc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk_i, nrst_i, rst_pin_n_i, seq_event_i, eighth_is_gpo_i, ref_sel_ext_i;
	logic cfg_sum_ok_i, cfg_new_i, cfg_copy_done_i, sda_oe_o, cfg_restore_o, cfg_backup_o, seq_run_o;
	logic adc_ref_ext_o, host_wr_stb_o;
	logic [3:0]   bus_address_strap_i, reset_cause_o;
	logic [23:0]  ch_mode_i;
	logic [35:0]  ch_parent_i;
	logic [143:0] ch_delay_i;
	logic [119:0] ch_thresh_i;
	logic [11:0]  ch_pol_i;
	logic [7:0]   rail_in_reg_i, rail_enable_out_o, rail_enable_oe_o, host_wr_data_o;
	logic [79:0]  rail_volt_i;
	logic [2:0]   general_output_o, general_output_oe_o;
	logic [6:0]   bus_addr_o;
	logic         sda_o, scl_m, sda_m, scl_w, sda_w;
	int           n_errors = 0, total_checks = 0, cycles = 0, n_stb = 0;

	rsrc_top #(.BOR_CYCLES(20), .TICK_CYCLES(10)) rsrc_top_inst (.ref_clk_i, .nrst_i, .rst_pin_n_i,
		.seq_event_i, .scl_i(scl_w), .sda_i(sda_w), .sda_o, .sda_oe_o, .bus_address_strap_i,
		.eighth_is_gpo_i, .ch_mode_i, .ch_parent_i, .ch_delay_i, .ch_thresh_i, .ch_pol_i, .rail_in_reg_i,
		.rail_volt_i, .cfg_sum_ok_i, .cfg_new_i, .cfg_copy_done_i, .ref_sel_ext_i, .rail_enable_out_o,
		.rail_enable_oe_o, .general_output_o, .general_output_oe_o, .cfg_restore_o, .cfg_backup_o,
		.seq_run_o, .reset_cause_o, .bus_addr_o, .adc_ref_ext_o, .host_wr_data_o, .host_wr_stb_o);
	rsrc_supply_model rsrc_supply_model_inst (.ref_clk_i, .en_i(rail_enable_out_o), .oe_i(rail_enable_oe_o),
		.pol_i(ch_pol_i[7:0]), .in_reg_o(rail_in_reg_i), .volt_o(rail_volt_i));
	// Open-drain bus lines; the slave only ever pulls SDA, so SCL is the master's own level
	assign scl_w = scl_m;
	assign sda_w = sda_oe_o ? sda_o : sda_m;
	// Write strobes last one cycle, so they are counted at every edge
	always @(posedge ref_clk_i) begin
		if (host_wr_stb_o === 1'b1) n_stb++;
	end

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// Hang guard: the whole run needs a few thousand cycles
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 8000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic wait_run();
		for (int k = 0; k < 3000 && seq_run_o !== 1'b1; k++) cyc(1);
		`CHK("run", 1'b1, seq_run_o)
	endtask
	// Hold the pin low; below 200 cycles it must be ignored
	task automatic pin_low(input int n);
		rst_pin_n_i = 1'b0;
		cyc(n);
		rst_pin_n_i = 1'b1;
	endtask
	// Host master bit: data set mid-low, sampled mid-high; a stretched SCL is waited for
	task automatic i2c_bit(input logic b, output logic r);
		sda_m = b;
		cyc(5);
		scl_m = 1'b1;
		cyc(5);
		for (int k = 0; k < 100 && scl_w !== 1'b1; k++) cyc(1);
		r = sda_w;
		cyc(5);
		scl_m = 1'b0;
		cyc(5);
	endtask
	task automatic i2c_start();
		sda_m = 1'b0;
		cyc(5);
		scl_m = 1'b0;
		cyc(5);
	endtask
	task automatic i2c_stop();
		sda_m = 1'b0;
		cyc(5);
		scl_m = 1'b1;
		cyc(5);
		sda_m = 1'b1;
		cyc(5);
	endtask
	// Byte out MSB first; ack is the level seen in the ninth bit, low when acknowledged
	task automatic i2c_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) i2c_bit(d[i], r);
		i2c_bit(1'b1, ack);
	endtask
	task automatic i2c_rd(input logic last, output logic [7:0] d);
		logic r;
		d = 8'h00;
		for (int i = 0; i < 8; i++) begin
			i2c_bit(1'b1, r);
			d = {d[6:0], r};
		end
		i2c_bit(last, r);
	endtask
	// Host port: write, foreign address, repeated status read, reference select, restart command
	task automatic t_bus();
		logic       ack;
		logic [7:0] d;
		int         n0;
		n0 = n_stb;
		i2c_start();
		i2c_byte(8'h74, ack);
		`CHK("wr addr ack", 1'b0, ack)
		i2c_byte(8'h3C, ack);
		`CHK("wr data ack", 1'b0, ack)
		i2c_stop();
		`CHK("wr data", 8'h3C, host_wr_data_o)
		`CHK("wr strobes", n0 + 1, n_stb)
		i2c_start();
		i2c_byte(8'h76, ack);
		i2c_stop();
		`CHK("foreign addr", 1'b1, ack)
		i2c_start();
		i2c_byte(8'h75, ack);
		`CHK("rd addr ack", 1'b0, ack)
		i2c_rd(1'b0, d);
		`CHK("status", 8'h81, d)
		i2c_rd(1'b1, d);
		i2c_stop();
		`CHK("status again", 8'h81, d)
		ref_sel_ext_i = 1'b0;
		cyc(2);
		`CHK("ref int", 1'b0, adc_ref_ext_o)
		i2c_start();
		i2c_byte(8'h74, ack);
		i2c_byte(8'hA5, ack);
		i2c_stop();
		`CHK("cmd data", 8'hA5, host_wr_data_o)
		wait_run();
		`CHK("cmd cause", 4'h8, reset_cause_o)
	endtask
	// Per-mode timing: reset delay 2 ms, parent regulation, parent threshold
	task automatic t_modes(input logic [7:0] exp_en);
		cyc(5);
		`CHK("ch1 early", 1'b1, rail_enable_out_o[1])
		`CHK("gpo2 early", 1'b0, general_output_o[0])
		cyc(35);
		`CHK("ch2 early", 1'b0, rail_enable_out_o[2])
		`CHK("ch3 early", 1'b0, rail_enable_out_o[3])
		cyc(210);
		`CHK("enables", exp_en, rail_enable_out_o)
		`CHK("gpo", 3'h7, general_output_o)
		`CHK("oe", 8'hFF, rail_enable_oe_o)
	endtask
	task automatic t_pin();
		pin_low(100);
		cyc(5);
		`CHK("short pin", 1'b1, seq_run_o)
		eighth_is_gpo_i = 1'b1;
		bus_address_strap_i = 4'h5;
		pin_low(260);
		`CHK("pin oe", 8'h00, rail_enable_oe_o)
		wait_run();
		`CHK("pin cause", 4'h2, reset_cause_o)
		`CHK("addr", 7'h35, bus_addr_o)
		t_modes(8'h8C);
	endtask
	task automatic t_seq();
		seq_event_i = 1'b1;
		cyc(1);
		seq_event_i = 1'b0;
		cyc(1);
		`CHK("seq off", 8'h02, rail_enable_out_o)
		cyc(1);
		`CHK("seq oe", 8'h00, rail_enable_oe_o)
		wait_run();
		`CHK("seq cause", 4'h4, reset_cause_o)
		cyc(5);
		`CHK("timer cleared", 1'b1, rail_enable_out_o[1])
	endtask
	// Bad checksum restores, a new set is backed up; run waits for the copy
	task automatic t_cfg(input logic bk);
		logic ack;
		cfg_sum_ok_i = bk;
		cfg_new_i = bk;
		pin_low(250);
		for (int k = 0; k < 200 && (bk ? cfg_backup_o : cfg_restore_o) !== 1'b1; k++) cyc(1);
		cyc(30);
		`CHK("copy", 1'b1, bk ? cfg_backup_o : cfg_restore_o)
		`CHK("held", 1'b0, seq_run_o)
		i2c_start();
		i2c_byte(8'h6A, ack);
		i2c_stop();
		`CHK("reset nack", 1'b1, ack)
		cfg_copy_done_i = 1'b1;
		wait_run();
		cfg_copy_done_i = 1'b0;
		cfg_sum_ok_i = 1'b1;
		cfg_new_i = 1'b0;
		`CHK("copy off", 1'b0, bk ? cfg_backup_o : cfg_restore_o)
	endtask
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		nrst_i = 1'b0;
		rst_pin_n_i = 1'b1;
		seq_event_i = 1'b0;
		eighth_is_gpo_i = 1'b0;
		ref_sel_ext_i = 1'b1;
		scl_m = 1'b1;
		sda_m = 1'b1;
		bus_address_strap_i = 4'hA;
		cfg_sum_ok_i = 1'b1;
		cfg_new_i = 1'b0;
		cfg_copy_done_i = 1'b0;
		ch_mode_i = {2'h0, 2'h0, 2'h1, 2'h1, 8'h00, 2'h3, 2'h2, 2'h1, 2'h0};
		ch_parent_i = {24'h0, 3'h2, 3'h1, 6'h00};
		ch_delay_i = {24'h0, 12'h003, 12'h000, 48'h0, 12'h000, 12'h001, 12'h002, 12'h000};
		ch_thresh_i = {80'h0, 10'h100, 30'h0};
		ch_pol_i = 12'h3FD;
		cyc(10);
		`CHK("reset oe", 8'h00, rail_enable_oe_o)
		`CHK("reset cause", 4'h1, reset_cause_o)
		nrst_i = 1'b1;
		wait_run();
		`CHK("por addr", 7'h3A, bus_addr_o)
		`CHK("ref", 1'b1, adc_ref_ext_o)
		t_modes(8'h0C);
		t_bus();
		t_pin();
		t_seq();
		t_cfg(1'b0);
		t_cfg(1'b1);
		print_verdict();
	end
endmodule // rsrc_top_bench
